/* hw/mpi_pkg.sv */
// package: constants, command and state types for the microcontroller port interface
`default_nettype none
package mpi_pkg;
    localparam int          DATA_W      = 8;
    localparam int          PC_W        = 10;
    localparam int          STACK_DEPTH = 31;
    localparam int          SP_W        = 5;
    localparam int          FIFO_DEPTH  = 4;
    localparam logic [9:0]  INT_VECTOR  = 10'h3ff;
    localparam logic [9:0]  RESET_PC    = 10'h000;
    localparam logic [9:0]  PC_STEP     = 10'h001;
    localparam logic [4:0]  SP_RESET    = 5'h00;
    localparam logic [4:0]  SP_LAST     = 5'h1e;
    localparam logic [4:0]  SP_STEP     = 5'h01;
    localparam logic [7:0]  BYTE_RESET  = 8'h00;
    localparam int          FLAG_Z_BIT  = 0;
    localparam int          FLAG_C_BIT  = 1;
    localparam int          IE_BIT      = 0;

    typedef enum logic [2:0] {
        OP_NOP    = 3'h0,
        OP_INPUT  = 3'h1,
        OP_OUTPUT = 3'h2,
        OP_EINT   = 3'h3,
        OP_DINT   = 3'h4,
        OP_RETI   = 3'h5,
        OP_FLAGS  = 3'h6
    } mpi_op_t;

    typedef struct packed {
        mpi_op_t     op;
        logic [7:0]  port_address_bus;
        logic [7:0]  data;
    } mpi_cmd_t;

    localparam int CMD_W = $bits(mpi_cmd_t);

    typedef enum logic [1:0] {
        ST_IDLE   = 2'h0,
        ST_FIRST  = 2'h1,
        ST_SECOND = 2'h2
    } mpi_state_t;
endpackage
`default_nettype wire

/* hw/mpi_cmd_fifo.sv */
// small flip-flop fifo holding queued port-interface commands
`default_nettype none
module mpi_cmd_fifo #(
    parameter int WIDTH = 19,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic             i_ref_clk,
    input  wire logic             i_reset,
    // filling side
    input  wire logic             i_in_valid,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_in_ready,
    // draining side
    output logic                  o_out_valid,
    output logic      [WIDTH-1:0] o_out_data,
    input  wire logic             i_out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
    localparam logic [CW-1:0] CNT_ONE  = CW'(1);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ptr_ff;
    logic [AW-1:0]    rd_ptr_ff;
    logic [CW-1:0]    cnt_ff;
    logic [CW-1:0]    nxt_cnt;
    logic             in_ready_ff;
    logic             push;
    logic             pop;

    function automatic logic [AW-1:0] ptr_next(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + AW'(1));
    endfunction

    assign o_in_ready  = in_ready_ff;
    assign o_out_valid = (cnt_ff != '0);
    assign o_out_data  = mem_ff[rd_ptr_ff];
    assign push        = i_in_valid && in_ready_ff;
    assign pop         = o_out_valid && i_out_ready;

    always_comb begin
        nxt_cnt = cnt_ff;
        if (push && !pop) begin
            nxt_cnt = cnt_ff + CNT_ONE;
        end else if (pop && !push) begin
            nxt_cnt = cnt_ff - CNT_ONE;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            cnt_ff      <= '0;
            in_ready_ff <= 1'b1;
            wr_ptr_ff   <= '0;
            rd_ptr_ff   <= '0;
        end else begin
            cnt_ff      <= nxt_cnt;
            // ready is registered so back-pressure never has a combinational path
            in_ready_ff <= (nxt_cnt != CNT_FULL);
            if (push) begin
                wr_ptr_ff <= ptr_next(wr_ptr_ff);
            end
            if (pop) begin
                rd_ptr_ff <= ptr_next(rd_ptr_ff);
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= i_in_data;
        end
    end
endmodule
`default_nettype wire

/* hw/mpi_port_if.sv */
// port interface engine: two-cycle port accesses, interrupt and reset events
//
// What the document requires of this block and its peripherals
// RULE1: all storage updates on rising clock edge; the code also clears registers asynchronously on i_reset, except stack and fifo contents and cfg_done_ff
// RULE2: peripheral holds input data; captured at edge
// RULE3: source holds interrupt high two cycles minimum
// RULE4: interrupt input ignored while enable flag clear
// RULE5: reset input held high one cycle minimum
// RULE6: automatic reset event after configuration completes
// RULE7: written byte on output bus two cycles
// RULE8: port address held two cycles per access
// RULE9: read pulse only in second access cycle
// RULE10: write pulse only in second access cycle
// RULE11: peripheral latches data when write pulse high
// RULE12: acknowledge high in second interrupt cycle
// RULE13: read pulse usable as fifo pop acknowledge
// RULE14: acknowledge may clear pending interrupt source
// RULE15: interrupt saves flags, pushes pc, jumps vector
// RULE16: reset clears pc, flags, enable and stack
// RULE17: strobes one cycle each, never together
`default_nettype none
module mpi_port_if
    import mpi_pkg::*;
(
    // clock and reset
    input  wire logic              i_ref_clk,
    input  wire logic              i_reset,
    // command queue from the instruction side
    input  wire logic              i_cmd_valid,
    input  wire mpi_cmd_t          i_cmd,
    output logic                   o_cmd_ready,
    // peripheral port bus
    input  wire logic [DATA_W-1:0] i_in_port,
    output logic      [DATA_W-1:0] o_out_port,
    output logic      [DATA_W-1:0] o_port_address_bus,
    output logic                   o_read_strobe,
    output logic                   o_write_strobe,
    // interrupt
    input  wire logic              i_interrupt,
    output logic                   o_interrupt_ack,
    // results and state
    output logic      [DATA_W-1:0] o_rd_data,
    output logic                   o_rd_valid,
    output logic      [PC_W-1:0]   o_pc,
    output logic      [1:0]        o_flags,
    output logic                   o_int_enable
);
    mpi_state_t        state_ff;
    mpi_cmd_t          cur_ff;
    logic              int_evt_ff;
    logic [PC_W-1:0]   pc_ff;
    logic              flag_z_ff;
    logic              flag_c_ff;
    logic              save_z_ff;
    logic              save_c_ff;
    logic              ie_ff;
    logic [SP_W-1:0]   sp_ff;
    logic [PC_W-1:0]   stack_ff [STACK_DEPTH];
    logic              cfg_done_ff = 1'b0;
    logic              q_valid;
    mpi_cmd_t          q_cmd;
    logic              boundary;
    logic              int_take;
    logic              cmd_take;
    logic              commit;
    logic              cmd_commit;
    logic              is_push;
    logic              is_pop;
    logic [SP_W-1:0]   sp_dec;

    function automatic logic [SP_W-1:0] sp_inc(input logic [SP_W-1:0] p);
        return (p == SP_LAST) ? SP_RESET : SP_W'(p + SP_STEP);
    endfunction

    // the stack is cyclic: the oldest entry is overwritten when it is full
    assign sp_dec = (sp_ff == SP_RESET) ? SP_LAST : SP_W'(sp_ff - SP_STEP);

    mpi_cmd_fifo #(
        .WIDTH (CMD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_cmd_fifo (
        .i_ref_clk   (i_ref_clk),
        .i_reset     (i_reset),
        .i_in_valid  (i_cmd_valid),
        .i_in_data   (i_cmd),
        .o_in_ready  (o_cmd_ready),
        .o_out_valid (q_valid),
        .o_out_data  (q_cmd),
        .i_out_ready (cmd_take)
    );

    // a new access may start while the previous one finishes its second cycle;
    // a DINT or interrupt still in flight holds off a new interrupt
    assign boundary   = cfg_done_ff && (state_ff != ST_FIRST);
    assign int_take   = boundary && ie_ff && i_interrupt                      // RULE4
                        && !(state_ff == ST_SECOND && (int_evt_ff || cur_ff.op == OP_DINT));
    assign cmd_take   = boundary && !int_take && q_valid;
    assign commit     = (state_ff == ST_SECOND);
    assign cmd_commit = commit && !int_evt_ff;
    assign is_push    = commit && int_evt_ff;
    assign is_pop     = cmd_commit && (cur_ff.op == OP_RETI);

    // power-up reset event: the flop's configured value blocks new accesses and holds pc, flags, enable and stack pointer in reset
    always_ff @(posedge i_ref_clk) begin
        cfg_done_ff <= 1'b1; // RULE6
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin // RULE1 RULE5
        if (i_reset) begin
            state_ff   <= ST_IDLE;
            cur_ff     <= '0;
            int_evt_ff <= 1'b0;
        end else if (int_take) begin
            state_ff   <= ST_FIRST;
            cur_ff     <= '0;
            int_evt_ff <= 1'b1;
        end else if (cmd_take) begin
            state_ff   <= ST_FIRST;
            cur_ff     <= q_cmd;
            int_evt_ff <= 1'b0;
        end else if (state_ff == ST_FIRST) begin
            state_ff   <= ST_SECOND;
        end else begin
            state_ff   <= ST_IDLE;
        end
    end

    // port bus: address and data stand from the first cycle through the second
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            o_port_address_bus <= BYTE_RESET;
            o_out_port         <= BYTE_RESET;
        end else if (cmd_take) begin
            if (q_cmd.op == OP_INPUT || q_cmd.op == OP_OUTPUT) begin
                o_port_address_bus <= q_cmd.port_address_bus; // RULE8
            end
            if (q_cmd.op == OP_OUTPUT) begin
                o_out_port <= q_cmd.data; // RULE7
            end
        end
    end

    // strobes and acknowledge rise for the second cycle only
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            o_read_strobe   <= 1'b0;
            o_write_strobe  <= 1'b0;
            o_interrupt_ack <= 1'b0;
        end else begin
            o_read_strobe   <= (state_ff == ST_FIRST) && !int_evt_ff
                               && (cur_ff.op == OP_INPUT); // RULE9 RULE17
            o_write_strobe  <= (state_ff == ST_FIRST) && !int_evt_ff
                               && (cur_ff.op == OP_OUTPUT); // RULE10 RULE17
            o_interrupt_ack <= (state_ff == ST_FIRST) && int_evt_ff; // RULE12
        end
    end

    // input byte is taken on the edge that closes the read strobe cycle
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            o_rd_data  <= BYTE_RESET;
            o_rd_valid <= 1'b0;
        end else begin
            o_rd_valid <= o_read_strobe;
            if (o_read_strobe) begin
                o_rd_data <= i_in_port; // RULE2
            end
        end
    end

    // program counter, flags, enable and stack pointer
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            pc_ff     <= RESET_PC; // RULE16
            flag_z_ff <= 1'b0;
            flag_c_ff <= 1'b0;
            save_z_ff <= 1'b0;
            save_c_ff <= 1'b0;
            ie_ff     <= 1'b0;
            sp_ff     <= SP_RESET;
        end else if (!cfg_done_ff) begin
            pc_ff     <= RESET_PC; // RULE6 RULE16
            flag_z_ff <= 1'b0;
            flag_c_ff <= 1'b0;
            save_z_ff <= 1'b0;
            save_c_ff <= 1'b0;
            ie_ff     <= 1'b0;
            sp_ff     <= SP_RESET;
        end else if (is_push) begin
            save_z_ff <= flag_z_ff; // RULE15
            save_c_ff <= flag_c_ff;
            ie_ff     <= 1'b0;
            pc_ff     <= INT_VECTOR;
            sp_ff     <= sp_inc(sp_ff);
        end else if (is_pop) begin
            pc_ff     <= stack_ff[sp_dec];
            sp_ff     <= sp_dec;
            flag_z_ff <= save_z_ff;
            flag_c_ff <= save_c_ff;
            ie_ff     <= cur_ff.data[IE_BIT];
        end else if (cmd_commit) begin
            pc_ff <= PC_W'(pc_ff + PC_STEP);
            if (cur_ff.op == OP_EINT) begin
                ie_ff <= 1'b1;
            end else if (cur_ff.op == OP_DINT) begin
                ie_ff <= 1'b0;
            end else if (cur_ff.op == OP_FLAGS) begin
                flag_z_ff <= cur_ff.data[FLAG_Z_BIT];
                flag_c_ff <= cur_ff.data[FLAG_C_BIT];
            end
        end
    end

    // stack contents are data and survive reset; only the pointer is cleared
    always_ff @(posedge i_ref_clk) begin
        if (is_push && cfg_done_ff) begin
            stack_ff[sp_ff] <= pc_ff; // RULE15
        end
    end

    assign o_pc         = pc_ff;
    assign o_flags      = {flag_c_ff, flag_z_ff};
    assign o_int_enable = ie_ff;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);

    rd_strobe_once_a: assert property (o_read_strobe |=> !o_read_strobe) // RULE17
        else $error("read strobe longer than one cycle");
    strobe_excl_a: assert property (!(o_read_strobe && o_write_strobe)) // RULE17
        else $error("read and write strobes together");
    rd_second_a: assert property ( // RULE9
        (state_ff == ST_SECOND && !int_evt_ff && cur_ff.op == OP_INPUT) == o_read_strobe)
        else $error("read strobe outside second read cycle");
    wr_second_a: assert property ( // RULE10
        (state_ff == ST_SECOND && !int_evt_ff && cur_ff.op == OP_OUTPUT) == o_write_strobe)
        else $error("write strobe outside second write cycle");
    addr_hold_a: assert property ( // RULE8
        (state_ff == ST_FIRST && !int_evt_ff) |=> $stable(o_port_address_bus) && commit)
        else $error("port address not held for two cycles");
    out_hold_a: assert property ( // RULE7
        (state_ff == ST_FIRST && cur_ff.op == OP_OUTPUT && !int_evt_ff)
        |=> $stable(o_out_port) && o_write_strobe)
        else $error("output byte not held for two cycles");
    ack_second_a: assert property ( // RULE12
        o_interrupt_ack == (state_ff == ST_SECOND && int_evt_ff))
        else $error("interrupt ack outside second event cycle");
    int_ignore_a: assert property ( // RULE4
        !ie_ff |=> !(state_ff == ST_FIRST && int_evt_ff))
        else $error("interrupt taken while disabled");
    int_vector_a: assert property ( // RULE15
        (commit && int_evt_ff) |=> (pc_ff == INT_VECTOR) && !ie_ff && (sp_ff == sp_inc($past(sp_ff))))
        else $error("interrupt event did not vector");
    rd_capture_a: assert property ( // RULE2
        o_read_strobe |=> o_rd_valid && (o_rd_data == $past(i_in_port)))
        else $error("input byte not captured");

    read_seen_c:  cover property (o_read_strobe ##1 o_rd_valid);
    write_seen_c: cover property (o_write_strobe);
    int_seen_c:   cover property (int_take ##2 o_interrupt_ack);
    b2b_c:        cover property (o_write_strobe ##2 o_write_strobe);
endmodule
`default_nettype wire

/* tb/mpi_periph_model.sv */
// peripheral model: popping input source, write log and interrupt source
`default_nettype none
module mpi_periph_model
    import mpi_pkg::*;
(
    // clock and reset
    input  wire logic              i_ref_clk,
    input  wire logic              i_reset,
    // port bus from the block
    input  wire logic [DATA_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_out_port,
    input  wire logic              i_read_strobe,
    input  wire logic              i_write_strobe,
    output logic      [DATA_W-1:0] o_in_port,
    // interrupt source
    input  wire logic              i_raise,
    input  wire logic              i_drop,
    input  wire logic              i_interrupt_ack,
    output logic                   o_interrupt
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] wr_addr [8];
    logic [7:0] wr_data [8];
    logic [7:0] prev_addr;
    logic [7:0] prev_out;
    int         wr_cnt;
    int         pop_cnt;
    int         ack_cnt;
    int         hold_err;
    int         both_err;
    // byte follows the pop count, so a lost or doubled pop changes the data seen
    assign o_in_port = i_addr + 8'(pop_cnt);
    always @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            wr_cnt <= 0;
            pop_cnt <= 0;
            ack_cnt <= 0;
            hold_err <= 0;
            both_err <= 0;
            prev_addr <= 8'h00;
            prev_out <= 8'h00;
            o_interrupt <= 1'b0;
        end else begin
            prev_addr <= i_addr;
            prev_out <= i_out_port;
            if (i_write_strobe && wr_cnt < 8) begin
                wr_addr[wr_cnt] <= i_addr;
                wr_data[wr_cnt] <= i_out_port;
                wr_cnt <= wr_cnt + 1;
            end
            if ((i_write_strobe || i_read_strobe) && prev_addr !== i_addr) begin
                hold_err <= hold_err + 1;
            end
            if (i_write_strobe && prev_out !== i_out_port) begin
                hold_err <= hold_err + 1;
            end
            if (i_read_strobe) begin
                pop_cnt <= pop_cnt + 1;
            end
            if (i_read_strobe && i_write_strobe) begin
                both_err <= both_err + 1;
            end
            if (i_interrupt_ack) begin
                ack_cnt <= ack_cnt + 1;
            end
            // request stays up until acknowledged or dropped by i_drop; i_drop can end it one cycle after i_raise
            if (i_raise) begin
                o_interrupt <= 1'b1;
            end else if (i_interrupt_ack || i_drop) begin
                o_interrupt <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

/* tb/tb.sv */
// testbench for the port interface engine
`default_nettype none
module tb
    import mpi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_ref_clk, i_reset, i_cmd_valid, o_cmd_ready, rs, ws, irq, ack;
    logic rd_valid, ie, raise, drop;
    mpi_cmd_t i_cmd;
    logic [7:0] in_port, out_port, addr, rd_data;
    logic [9:0] pc;
    logic [1:0] flags;
    int fails, cmp_count, refused;

    mpi_port_if DUT (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_cmd_valid(i_cmd_valid),
        .i_cmd(i_cmd), .o_cmd_ready(o_cmd_ready), .i_in_port(in_port), .o_out_port(out_port),
        .o_port_address_bus(addr), .o_read_strobe(rs), .o_write_strobe(ws),
        .i_interrupt(irq), .o_interrupt_ack(ack), .o_rd_data(rd_data), .o_rd_valid(rd_valid),
        .o_pc(pc), .o_flags(flags), .o_int_enable(ie));
    mpi_periph_model u_per (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_addr(addr),
        .i_out_port(out_port), .i_read_strobe(rs), .i_write_strobe(ws), .o_in_port(in_port),
        .i_raise(raise), .i_drop(drop), .i_interrupt_ack(ack), .o_interrupt(irq));

    initial begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    function automatic bit hit(input int which);
        case (which)
            0: return rd_valid === 1'b1;
            1: return ack === 1'b1;
            2: return u_per.wr_cnt == 8;
            default: return ie === 1'b1;
        endcase
    endfunction

    // all waits are bounded; a hang ends the run as a mismatch
    task automatic wait_ev(input int which, input int lim);
        int n;
        n = 0;
        while (!hit(which) && n < lim) begin
            @(negedge i_ref_clk);
            n++;
        end
        if (!hit(which)) begin
            fails++;
            $display("CHECK FAILED at %0t: wait %0d timed out", $time, which);
            wrap_up();
        end
    endtask

    // leaves valid high so back-to-back calls offer a command every cycle
    task automatic send(input mpi_op_t op, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        i_cmd_valid = 1'b1;
        i_cmd = {op, a, d};
        while (o_cmd_ready !== 1'b1 && n < 50) begin
            @(negedge i_ref_clk);
            n++;
        end
        if (o_cmd_ready !== 1'b1) begin
            fails++;
            $display("CHECK FAILED at %0t: command refused too long", $time);
            wrap_up();
        end
        if (n > 0) refused++;
        @(negedge i_ref_clk);
    endtask

    task automatic idle(input int n);
        i_cmd_valid = 1'b0;
        repeat (n) @(negedge i_ref_clk);
    endtask

    task automatic s_reset_vals;
        chk(16'(pc), 16'h0000, "pc after reset");
        chk(16'({ie, flags}), 16'h0000, "enable and flags after reset");
        chk(16'({rs, ws, ack}), 16'h0000, "strobes idle");
    endtask

    task automatic s_burst;
        refused = 0;
        for (int i = 0; i < 8; i++) send(OP_OUTPUT, 8'h10 + 8'(i), 8'ha0 + 8'(i));
        idle(1);
        // two cycles per access drain slower than one offer per cycle fills
        chk(16'(refused > 0), 16'h0001, "queue never refused");
        wait_ev(2, 60);
        for (int i = 0; i < 8; i++) begin
            chk(16'(u_per.wr_addr[i]), 16'(8'h10 + 8'(i)), "write address");
            chk(16'(u_per.wr_data[i]), 16'(8'ha0 + 8'(i)), "write data");
        end
        chk(16'(u_per.hold_err), 16'h0000, "address or data not held");
    endtask

    task automatic s_read;
        send(OP_INPUT, 8'h20, 8'h00);
        send(OP_INPUT, 8'h21, 8'h00);
        idle(0);
        wait_ev(0, 20);
        chk(16'(rd_data), 16'h0020, "first read");
        @(negedge i_ref_clk);
        wait_ev(0, 20);
        chk(16'(rd_data), 16'h0022, "second read");
        idle(3);
        chk(16'(u_per.pop_cnt), 16'h0002, "read pulses");
        chk(16'(u_per.both_err + u_per.hold_err), 16'h0000, "strobe overlap");
    endtask

    task automatic s_int;
        logic [9:0] p;
        send(OP_FLAGS, 8'h00, 8'h03);
        idle(4);
        raise = 1'b1;
        @(negedge i_ref_clk);
        raise = 1'b0;
        idle(10);
        chk(16'(u_per.ack_cnt), 16'h0000, "taken while disabled");
        drop = 1'b1;
        @(negedge i_ref_clk);
        drop = 1'b0;
        send(OP_EINT, 8'h00, 8'h00);
        idle(4);
        p = pc;
        raise = 1'b1;
        @(negedge i_ref_clk);
        raise = 1'b0;
        wait_ev(1, 10);
        @(negedge i_ref_clk);
        chk(16'(pc), 16'h03ff, "vector");
        chk(16'(ie), 16'h0000, "enable after event");
        chk(16'({ack, irq}), 16'h0000, "ack length or source not cleared");
        chk(16'(u_per.ack_cnt), 16'h0001, "ack count");
        // flags are changed inside the handler so the restore is really seen
        send(OP_FLAGS, 8'h00, 8'h00);
        send(OP_RETI, 8'h00, 8'h01);
        idle(0);
        wait_ev(3, 20);
        chk(16'(pc), 16'(p), "return address");
        chk(16'(flags), 16'h0003, "saved flags");
        send(OP_DINT, 8'h00, 8'h00);
        idle(4);
        chk(16'(ie), 16'h0000, "enable after disable");
        raise = 1'b1;
        @(negedge i_ref_clk);
        raise = 1'b0;
        idle(6);
        chk(16'(u_per.ack_cnt), 16'h0001, "taken after disable");
        drop = 1'b1;
        @(negedge i_ref_clk);
        drop = 1'b0;
    endtask

    task automatic s_reset_mid;
        send(OP_EINT, 8'h00, 8'h00);
        idle(4);
        chk(16'(ie), 16'h0001, "enable before short reset");
        i_reset = 1'b1;
        @(negedge i_ref_clk);
        i_reset = 1'b0;
        @(negedge i_ref_clk);
        chk(16'(pc), 16'h0000, "pc after short reset");
        chk(16'({ie, flags}), 16'h0000, "state after short reset");
    endtask

    initial begin
        i_reset = 1'b1;
        i_cmd_valid = 1'b0;
        i_cmd = '0;
        raise = 1'b0;
        drop = 1'b0;
        repeat (8) @(negedge i_ref_clk);
        i_reset = 1'b0;
        @(negedge i_ref_clk);
        s_reset_vals();
        s_burst();
        s_read();
        s_int();
        s_reset_mid();
        wrap_up();
    end

    initial begin
        #200000;
        fails++;
        $display("CHECK FAILED at %0t: run time limit", $time);
        wrap_up();
    end
endmodule
`default_nettype wire
